// [hdl/scs_clock_ctrl.sv]
// Purpose: System clock source control: oscillator enables, crystal drive, glitch-free source mux.
// Assumes: Oscillator outputs are levels synchronous to CLK_SYS; register reads answer one cycle later.
// Notes: Software must not remove the running source; a disabled source reads zero.
// Notes: Fast RC divider taps are gated too, so none can stay frozen high.

`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [7:0] RDATA,
    input wire logic FAST_RC_CLK,
    input wire logic SLOW_RC_CLK,
    input wire logic XTAL_CLK,
    output logic FAST_RC_EN,
    output logic SLOW_RC_EN,
    output logic XTAL_EN,
    output logic [1:0] XTAL_DRIVE,
    output logic SYS_CLK,
    output logic SWITCH_BUSY
);

    localparam scs_pkg::scs_top_s RESET_STATE = '{
        xtal_ctrl: scs_pkg::XTAL_CTRL_RESET,
        clk_sel: scs_pkg::CLK_SEL_RESET,
        rdata: 8'h00,
        sw: scs_pkg::SW_IDLE,
        active: scs_pkg::SRC_SLOW,
        target: scs_pkg::SRC_SLOW,
        sys_clk: 1'h0
    };

    // Whole block state; next_st is its combinational copy
    scs_pkg::scs_top_s st;
    scs_pkg::scs_top_s next_st;
    logic [scs_pkg::DIV_TAPS-1:0] fast_taps;
    logic [scs_pkg::DIV_TAPS-1:0] tap_lvl;
    logic fast_lvl;
    logic slow_lvl;
    logic xtal_lvl;
    // Candidate levels, one per source code
    logic [7:0] cand_lvl;
    logic [7:0] status_word;
    // Source decoded from the selection being written or held
    scs_pkg::scs_src_e want;

    function automatic scs_pkg::scs_src_e sel_decode(input logic [7:0] sel);
        logic [2:0] mode;
        logic fine;
        mode = sel[scs_pkg::SEL_MODE_HI:scs_pkg::SEL_MODE_LO];
        fine = sel[scs_pkg::SEL_FINE_BIT];
        // Remaining codes fall back to the slowest fast RC tap
        case (mode)
            scs_pkg::MODE_SLOW: begin
                sel_decode = scs_pkg::SRC_SLOW;
            end
            scs_pkg::MODE_XTAL: begin
                sel_decode = scs_pkg::SRC_XTAL;
            end
            scs_pkg::MODE_FAST_A: begin
                sel_decode = fine ? scs_pkg::SRC_FAST_DIV8 : scs_pkg::SRC_FAST_DIV2;
            end
            scs_pkg::MODE_FAST_B: begin
                sel_decode = fine ? scs_pkg::SRC_FAST_DIV16 : scs_pkg::SRC_FAST_DIV4;
            end
            scs_pkg::MODE_FAST_C: begin
                sel_decode = fine ? scs_pkg::SRC_FAST_DIV32 : scs_pkg::SRC_FAST_DIV64;
            end
            default: begin
                sel_decode = scs_pkg::SRC_FAST_DIV64;
            end
        endcase
    endfunction

    // A disabled oscillator reads zero, so the switch logic never waits on it
    // independent enables gate each source
    assign fast_lvl = FAST_RC_CLK & st.clk_sel[scs_pkg::FAST_EN_BIT];
    assign slow_lvl = SLOW_RC_CLK & st.clk_sel[scs_pkg::SLOW_EN_BIT];
    assign xtal_lvl = XTAL_CLK & st.xtal_ctrl[scs_pkg::XTAL_EN_BIT];

    // Divider counts only while the fast RC runs; its taps are the fast sources
    scs_rc_div #(
        .TAPS(scs_pkg::DIV_TAPS)
    ) u_fast_div (
        .clk(CLK_SYS),
        .rst(RST),
        .src_level(fast_lvl),
        .taps(fast_taps)
    );

    // a stopped fast RC must not leave a divider tap frozen high
    for (genvar t = 0; t < scs_pkg::DIV_TAPS; t++) begin : g_tap_gate
        assign tap_lvl[t] = fast_taps[t] & st.clk_sel[scs_pkg::FAST_EN_BIT];
    end

    // Index order matches the source enum
    assign cand_lvl = {xtal_lvl, slow_lvl, tap_lvl};

    // Status: bit 0 busy, bits 3..1 active source, bits 6..4 target source
    assign status_word = {1'h0, st.target, st.active, st.sw[0]};

    always_comb begin
        next_st = st;
        // Read data stands only in the cycle after the strobe
        next_st.rdata = 8'h00;
        if (WR_STB) begin
            case (ADDR)
                scs_pkg::XTAL_CTRL_ADDR: begin
                    next_st.xtal_ctrl = WDATA;
                end
                scs_pkg::CLK_SEL_ADDR: begin
                    next_st.clk_sel = WDATA;
                end
                default: begin
                    // Status and unmapped addresses ignore writes
                end
            endcase
        end

        // Reads of unmapped addresses return zero
        if (RD_STB) begin
            case (ADDR)
                scs_pkg::XTAL_CTRL_ADDR: begin
                    next_st.rdata = st.xtal_ctrl;
                end
                scs_pkg::CLK_SEL_ADDR: begin
                    next_st.rdata = st.clk_sel;
                end
                scs_pkg::STATUS_ADDR: begin
                    next_st.rdata = status_word;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // new selection seen in the write cycle
        want = sel_decode(next_st.clk_sel);
        next_st.target = want;

        // hold low between old and new source
        unique case (st.sw)
            scs_pkg::SW_IDLE: begin
                // Follow the active source one cycle late
                next_st.sys_clk = cand_lvl[st.active];
                if (want != st.active) begin
                    next_st.sw = scs_pkg::SW_OLD_LOW;
                end
            end
            scs_pkg::SW_OLD_LOW: begin
                // Let the old high phase finish; writing the old source back cancels
                next_st.sys_clk = cand_lvl[st.active];
                if (want == st.active) begin
                    next_st.sw = scs_pkg::SW_IDLE;
                end else if (!cand_lvl[st.active]) begin
                    next_st.sys_clk = 1'h0;
                    next_st.sw = scs_pkg::SW_NEW_LOW;
                end
            end
            scs_pkg::SW_NEW_LOW: begin
                // gated sources read zero, so a removed source cannot stall here
                // Hold low until the new source is low, so its first high phase is whole
                next_st.sys_clk = 1'h0;
                if (!cand_lvl[want]) begin
                    next_st.active = want;
                    next_st.sw = scs_pkg::SW_IDLE;
                end
            end
            default: begin
                // Unused code recovers to idle
                next_st.sw = scs_pkg::SW_IDLE;
            end
        endcase
    end

    // Synchronous reset restores the boot selection
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // Every output is a register field, with no logic after the flops
    assign RDATA = st.rdata;
    assign FAST_RC_EN = st.clk_sel[scs_pkg::FAST_EN_BIT];
    assign SLOW_RC_EN = st.clk_sel[scs_pkg::SLOW_EN_BIT];
    assign XTAL_EN = st.xtal_ctrl[scs_pkg::XTAL_EN_BIT];
    assign XTAL_DRIVE = st.xtal_ctrl[scs_pkg::XTAL_DRV_HI:scs_pkg::XTAL_DRV_LO];
    assign SYS_CLK = st.sys_clk;
    assign SWITCH_BUSY = st.sw[0];
endmodule
`default_nettype wire

// [hdl/scs_pkg.sv]
// Purpose: Shared constants and types for the system clock source control block.
// Assumes: 8-bit register port; oscillator outputs arrive as levels sampled by CLK_SYS.
// Notes: Register addresses are byte addresses on the plain register port.
package scs_pkg;

    // Register addresses
    localparam logic [7:0] XTAL_CTRL_ADDR = 8'h0A;
    localparam logic [7:0] CLK_SEL_ADDR = 8'h03;
    localparam logic [7:0] STATUS_ADDR = 8'h0B;

    // Crystal control fields; drive codes 01 low, 10 middle, 11 high
    localparam int XTAL_EN_BIT = 7;
    localparam int XTAL_DRV_HI = 6;
    localparam int XTAL_DRV_LO = 5;

    // Clock select fields
    localparam int SEL_MODE_HI = 7;
    localparam int SEL_MODE_LO = 5;
    localparam int FAST_EN_BIT = 4;
    localparam int SEL_FINE_BIT = 3;
    localparam int SLOW_EN_BIT = 2;

    // Mode field codes
    localparam logic [2:0] MODE_SLOW = 3'h7;
    localparam logic [2:0] MODE_XTAL = 3'h5;
    localparam logic [2:0] MODE_FAST_A = 3'h1;
    localparam logic [2:0] MODE_FAST_B = 3'h0;
    localparam logic [2:0] MODE_FAST_C = 3'h3;

    // Reset values: slow RC runs the system, both RC oscillators enabled
    localparam logic [7:0] XTAL_CTRL_RESET = 8'h00;
    localparam logic [7:0] CLK_SEL_RESET = 8'hF4;

    // Fast RC divider taps: /2 up to /64
    localparam int DIV_TAPS = 6;

    // Source index doubles as bit index into the candidate level vector
    typedef enum logic [2:0] {
        SRC_FAST_DIV2 = 3'h0,
        SRC_FAST_DIV4 = 3'h1,
        SRC_FAST_DIV8 = 3'h2,
        SRC_FAST_DIV16 = 3'h3,
        SRC_FAST_DIV32 = 3'h4,
        SRC_FAST_DIV64 = 3'h5,
        SRC_SLOW = 3'h6,
        SRC_XTAL = 3'h7
    } scs_src_e;

    // Switch sequencer, Gray along idle -> old low -> new low; new low -> idle flips both bits
    typedef enum logic [1:0] {
        SW_IDLE = 2'h0,
        SW_OLD_LOW = 2'h1,
        SW_NEW_LOW = 2'h3
    } scs_sw_e;

    typedef struct packed {
        logic [7:0] xtal_ctrl;
        logic [7:0] clk_sel;
        logic [7:0] rdata;
        scs_sw_e sw;
        scs_src_e active;
        scs_src_e target;
        logic sys_clk;
    } scs_top_s;

endpackage

// [hdl/scs_rc_div.sv]
// Purpose: Power-of-two divider of the fast RC oscillator level.
// Assumes: Source level is sampled by clk and is much slower than clk.
// Notes: Tap i toggles at source / 2^(i+1).
`timescale 1ns/1ps
`default_nettype none
module scs_rc_div #(
    parameter int TAPS = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic src_level,
    output logic [TAPS-1:0] taps
);
    typedef struct packed {
        logic prev;
        logic [TAPS-1:0] cnt;
    } scs_div_s;

    scs_div_s st;
    scs_div_s next_st;

    always_comb begin
        next_st = st;
        next_st.prev = src_level;
        if (src_level && !st.prev) begin
            next_st.cnt = st.cnt + 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign taps = st.cnt;
endmodule
`default_nettype wire

// [sim/scs_osc_model.sv]
// Purpose: Oscillator levels seen by the clock control block.
// Assumes: A disabled oscillator rests low.
// Notes: Crystal swings only 32 cycles after its enable.
`timescale 1ns/1ps
`default_nettype none
module scs_osc_model (
    input wire logic clk,
    input wire logic fast_en,
    input wire logic slow_en,
    input wire logic xtal_en,
    output logic fast,
    output logic slow,
    output logic xtal
);
    logic [7:0] cnt = 8'h00;
    logic [5:0] age = 6'h00;
    always_ff @(posedge clk) begin
        cnt <= cnt + 8'h01;
        age <= xtal_en ? age + {5'h00, ~age[5]} : 6'h00;
    end
    assign fast = fast_en & cnt[1];
    assign slow = slow_en & cnt[4];
    assign xtal = xtal_en & age[5] & cnt[2];
endmodule
`default_nettype wire

// [sim/scs_clock_ctrl_chk.sv]
// Purpose: Port assertions for the clock control block.
// Assumes: Selected oscillators keep running.
// Notes: Runt checks need source half periods of 2+ cycles.
`timescale 1ns/1ps
`default_nettype none
module scs_clock_ctrl_chk (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_STB,
    input wire logic FAST_RC_EN,
    input wire logic SLOW_RC_EN,
    input wire logic XTAL_EN,
    input wire logic [1:0] XTAL_DRIVE,
    input wire logic SYS_CLK,
    input wire logic SWITCH_BUSY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence s_xwr;
        WR_STB && ADDR == scs_pkg::XTAL_CTRL_ADDR;
    endsequence
    sequence s_swr;
        WR_STB && ADDR == scs_pkg::CLK_SEL_ADDR;
    endsequence
    a_xtal_enable: assert property (s_xwr |=> XTAL_EN == $past(WDATA[7]))
        else $error("bad crystal enable");
    a_drive_field: assert property (s_xwr |=> XTAL_DRIVE == $past(WDATA[6:5]))
        else $error("bad drive field");
    a_fast_enable: assert property (s_swr |=> FAST_RC_EN == $past(WDATA[4]))
        else $error("bad fast enable");
    a_slow_stop: assert property (s_swr |=> SLOW_RC_EN == $past(WDATA[2]))
        else $error("bad slow enable");
    a_reset_rc_on: assert property ($fell(RST) |-> FAST_RC_EN && SLOW_RC_EN && !XTAL_EN)
        else $error("bad reset enables");
    a_switch_bounded: assert property ($rose(SWITCH_BUSY) |-> ##[1:400] !SWITCH_BUSY)
        else $error("switch too long");
    a_no_runt_high: assert property ($rose(SYS_CLK) |-> SYS_CLK [*2])
        else $error("short high pulse");
    a_no_runt_low: assert property ($fell(SYS_CLK) |-> (!SYS_CLK) [*2])
        else $error("short low pulse");
endmodule
bind scs_clock_ctrl scs_clock_ctrl_chk i_chk (.CLK_SYS, .RST, .ADDR, .WDATA, .WR_STB,
    .FAST_RC_EN, .SLOW_RC_EN, .XTAL_EN, .XTAL_DRIVE, .SYS_CLK, .SWITCH_BUSY);
`default_nettype wire

// [sim/tb.sv]
// Purpose: Self-checking bench for the clock control block.
// Assumes: Crystal model settles in 32 cycles.
// Notes: Random selects keep both RC oscillators on, so no switch hangs.
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Source code per {mode, fine bit}, index 15 at the top
    localparam logic [47:0] SRC_MAP = 48'hDADFED96D419;
    logic clk = 0, rst = 1, wr = 0, rd = 0, fc, sc, xc, fe, se, xe, sys, busy;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, d;
    logic [1:0] drv;
    logic [15:0] seed = 16'h005F;
    int errors = 0, cmp_count = 0, cyc = 0;
    logic [15:0] steps [11] = '{16'h0334, 16'h0314, 16'h03F4, 16'h0334, 16'h0330, 16'h0AE0,
        16'h03B0, 16'h03A0, 16'h03A4, 16'h03E4, 16'h0A00};
    scs_clock_ctrl i_scs_clock_ctrl (.CLK_SYS(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR_STB(wr),
        .RD_STB(rd), .RDATA(rdata), .FAST_RC_CLK(fc), .SLOW_RC_CLK(sc), .XTAL_CLK(xc), .FAST_RC_EN(fe),
        .SLOW_RC_EN(se), .XTAL_EN(xe), .XTAL_DRIVE(drv), .SYS_CLK(sys), .SWITCH_BUSY(busy));
    scs_osc_model i_scs_osc_model (.clk(clk), .fast_en(fe), .slow_en(se), .xtal_en(xe), .fast(fc),
        .slow(sc), .xtal(xc));
    initial forever #2 clk = ~clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 7;
        seed ^= seed >> 9;
        seed ^= seed << 8;
        return seed[7:0];
    endfunction
    function automatic logic [2:0] src_of(input logic [7:0] s);
        return SRC_MAP[{s[7:5], s[3]} * 3 +: 3];
    endfunction
    task automatic chk(input string n, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, x);
        @(posedge clk);
        addr <= a;
        wdata <= x;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
        #1 v = rdata;
    endtask
    task automatic sel(input logic [7:0] x);
        logic p;
        bus(1'h1, scs_pkg::CLK_SEL_ADDR, x);
        for (int n = 0; n < 400 && busy !== 1'h0; n++) @(posedge clk) #1;
        chk("busy", {7'h00, busy}, 8'h00);
        chk("rc_en", {6'h00, fe, se}, {6'h00, x[4], x[2]});
        bus(1'h0, scs_pkg::STATUS_ADDR, 8'h00);
        chk("status", v, {1'h0, src_of(x), src_of(x), 1'h0});
        // Idle clock follows slow RC or crystal one cycle late
        for (int n = 0; n < 40 && src_of(x) > 3'h5; n++) begin
            p = src_of(x) == 3'h6 ? sc : xc;
            @(posedge clk) #1;
            chk("sys_clk", {7'h00, sys}, {7'h00, p});
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        bus(1'h0, scs_pkg::CLK_SEL_ADDR, 8'h00);
        chk("sel_reset", v, 8'hF4);
        chk("rc_reset", {6'h00, fe, se}, 8'h03);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            d = rnd();
            d[6:5] = i[1:0];
            bus(1'h1, scs_pkg::XTAL_CTRL_ADDR, d);
            chk("xtal", {5'h00, xe, drv}, {5'h00, d[7:5]});
            bus(1'h0, scs_pkg::XTAL_CTRL_ADDR, 8'h00);
            chk("xtal_rd", v, d);
            bus(1'h0, rnd() | 8'h10, 8'h00);
            chk("unmapped", v, 8'h00);
        end
        $display("crystal test done");
        foreach (steps[k]) begin
            if (steps[k][15:8] == scs_pkg::XTAL_CTRL_ADDR) begin
                bus(1'h1, steps[k][15:8], steps[k][7:0]);
                chk("xtal_en", {7'h00, xe}, {7'h00, steps[k][7]});
                repeat (40) @(posedge clk);
            end else begin
                sel(steps[k][7:0]);
            end
        end
        $display("switch test done");
        sel(8'hF4);
        for (int i = 0; i < 12; i++) begin
            d = rnd() | 8'h14;
            if (d[7:5] == 3'h5) d[5] = 1'h0;
            sel(d);
        end
        $display("random test done");
        final_report();
    end
endmodule
`default_nettype wire
